//--- common/rsl_pkg.sv
// reset strap latch: shared constants, register map and carrier types
// assumes a 100 MHz clk and an MII style 5 bit register index on the plain bus
package rsl_pkg;

  localparam int unsigned RSL_ADDR_W = 5;
  localparam int unsigned RSL_DATA_W = 16;
  localparam int unsigned RSL_STRAP_W = 10;
  localparam int unsigned RSL_SYNC_STAGES = 2;

  // register indices
  localparam logic [4:0] RSL_REG_CTRL = 5'h00;
  localparam logic [4:0] RSL_REG_ADV = 5'h04;
  localparam logic [4:0] RSL_REG_OPT = 5'h16;
  localparam logic [4:0] RSL_REG_STRAP = 5'h18;

  // control register fields
  localparam int unsigned RSL_CTRL_SPEED_BIT = 13;
  localparam int unsigned RSL_CTRL_ANEN_BIT = 12;
  localparam int unsigned RSL_CTRL_ISO_BIT = 10;
  localparam int unsigned RSL_CTRL_DUPLEX_BIT = 8;
  localparam logic RSL_CTRL_ANEN_RST = 1'h1;

  // advertisement register fields
  localparam int unsigned RSL_ADV_100FD_BIT = 8;
  localparam int unsigned RSL_ADV_100HD_BIT = 7;
  localparam int unsigned RSL_ADV_10FD_BIT = 6;
  localparam int unsigned RSL_ADV_10HD_BIT = 5;
  localparam logic [4:0] RSL_ADV_SELECTOR = 5'h01;

  // option register fields
  localparam int unsigned RSL_OPT_BCAST_OFF_BIT = 9;

  // strap status register fields
  localparam int unsigned RSL_STS_ADDR_LSB = 0;
  localparam int unsigned RSL_STS_BCAST_BIT = 3;
  localparam int unsigned RSL_STS_MODE_LSB = 4;
  localparam int unsigned RSL_STS_ISO_BIT = 7;
  localparam int unsigned RSL_STS_SPEED_BIT = 8;
  localparam int unsigned RSL_STS_DUPLEX_BIT = 9;
  localparam int unsigned RSL_STS_VALID_BIT = 15;

  // management address layout
  localparam int unsigned RSL_MGMT_ADDR_W = 5;
  localparam logic [1:0] RSL_MGMT_ADDR_HI = 2'h0;
  localparam logic [4:0] RSL_BCAST_ADDR = 5'h00;

  // interface mode patterns
  localparam logic [2:0] RSL_MODE_RMII = 3'h1;
  localparam logic [2:0] RSL_MODE_B2B = 3'h5;

  typedef struct packed {
    logic [2:0] mgmt_addr;
    logic bcast_off;
    logic [2:0] mode;
    logic isolate;
    logic speed;
    logic duplex;
  } rsl_straps_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rsl_bus_req_t;

  typedef struct packed {
    logic [4:0] mgmt_addr;
    logic bcast_en;
    logic mode_rmii;
    logic mode_b2b;
    logic mode_reserved;
    logic isolate;
    logic speed100;
    logic full_duplex;
    logic an_enable;
  } rsl_cfg_t;

  typedef enum logic
  {
    RSL_ST_STRAP = 1'b0,
    RSL_ST_RUN = 1'b1
  } rsl_state_t;

endpackage

//--- logic/rsl_sync.sv
// reset strap latch: two stage level synchroniser for strap pins
// assumes inputs are asynchronous levels; first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module rsl_sync
#(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STAGES = 2
)
(
  input wire logic clk,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_q [STAGES];

  if (STAGES < 2)
  begin : g_bad_stages
    $error("rsl_sync needs at least two stages");
  end

  // no reset: the chain must keep tracking the pins while reset is held
  always_ff @(posedge clk)
  begin
    stage_q[0] <= async_in;
    for (int i = 1; i < STAGES; i++)
    begin
      stage_q[i] <= stage_q[i-1];
    end
  end

  assign sync_out = stage_q[STAGES-1];

endmodule
`default_nettype wire

//--- logic/rsl_pad_group.sv
// reset strap latch: output side of a group of dual purpose strap pins
// assumes run rises once straps are latched; pins stay inputs until then
`timescale 1ns/10ps
`default_nettype none
module rsl_pad_group
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [WIDTH-1:0] func_out,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe
);

  logic [WIDTH-1:0] pin_o_d;
  logic [WIDTH-1:0] pin_oe_d;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("rsl_pad_group needs a width of one or more");
  end

  always_comb
  begin
    pin_o_d = '0;
    pin_oe_d = '0;
    if (rstn && run)
    begin
      pin_o_d = func_out;
      pin_oe_d = '1;
    end
  end

  always_ff @(posedge clk)
  begin
    pin_o <= pin_o_d;
    pin_oe <= pin_oe_d;
  end

endmodule
`default_nettype wire

//--- logic/rsl_strap_latch.sv
// reset strap latch: samples strap pins at reset release, loads control
// and advertisement registers, then hands the pins to their outputs
// assumes strap pins are asynchronous, pulls are on the board or pad ring,
// and the register port is driven from logic on clk
`timescale 1ns/10ps
`default_nettype none
module rsl_strap_latch
(
  input wire logic clk,
  input wire logic rstn,
  input wire rsl_pkg::rsl_straps_t strap_pin_i,
  output rsl_pkg::rsl_straps_t strap_pin_o,
  output rsl_pkg::rsl_straps_t strap_pin_oe,
  input wire rsl_pkg::rsl_straps_t strap_func_out,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [4:0] mgmt_req_addr,
  output logic mgmt_addr_hit,
  output rsl_pkg::rsl_cfg_t cfg,
  output logic straps_valid
);

  import rsl_pkg::*;

  rsl_straps_t strap_sync;
  rsl_straps_t strap_q;
  rsl_straps_t strap_d;
  rsl_state_t state_q;
  rsl_state_t state_d;
  rsl_bus_req_t req;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] adv_q;
  logic [15:0] adv_d;
  logic [15:0] opt_q;
  logic [15:0] opt_d;
  logic [15:0] rdata_d;
  logic [15:0] status_word;
  logic [4:0] mgmt_addr;
  logic bcast_en;
  logic capture;
  logic [2:0] mode_bits;

  // the strap carrier and the pad width must agree bit for bit
  if ($bits(rsl_straps_t) != RSL_STRAP_W)
  begin : g_bad_strap_w
    $error("strap carrier width differs from strap pin count");
  end

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  rsl_sync
  #(
    .WIDTH(RSL_STRAP_W),
    .STAGES(RSL_SYNC_STAGES)
  )
  u_sync
  (
    .clk(clk),
    .async_in(strap_pin_i),
    .sync_out(strap_sync)
  );

  rsl_pad_group
  #(
    .WIDTH(RSL_STRAP_W)
  )
  u_pads
  (
    .clk(clk),
    .rstn(rstn),
    .run(state_q == RSL_ST_RUN),
    .func_out(strap_func_out),
    .pin_o(strap_pin_o),
    .pin_oe(strap_pin_oe)
  );

  // capture happens on the first edge with reset released; the sync chain
  // has been tracking the pins throughout reset, so its value is settled
  assign capture = (state_q == RSL_ST_STRAP) && rstn;

  always_comb
  begin
    state_d = state_q;
    strap_d = strap_q;
    if (!rstn)
    begin
      state_d = RSL_ST_STRAP;
    end
    else
    begin
      unique case (state_q)
        RSL_ST_STRAP:
        begin
          strap_d = strap_sync;
          state_d = RSL_ST_RUN;
        end
        RSL_ST_RUN:
        begin
          state_d = RSL_ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    state_q <= state_d;
    strap_q <= strap_d;
  end

  // register next values; capture loads defaults from the straps and
  // overrides any write in the same cycle
  always_comb
  begin
    ctrl_d = ctrl_q;
    adv_d = adv_q;
    opt_d = opt_q;
    if (!rstn)
    begin
      ctrl_d = '0;
      ctrl_d[RSL_CTRL_ANEN_BIT] = RSL_CTRL_ANEN_RST;
      adv_d = {11'h000, RSL_ADV_SELECTOR};
      opt_d = '0;
    end
    else if (capture)
    begin
      ctrl_d[RSL_CTRL_SPEED_BIT] = strap_sync.speed;
      ctrl_d[RSL_CTRL_ISO_BIT] = strap_sync.isolate;
      // strap high means half duplex, control bit set means full
      ctrl_d[RSL_CTRL_DUPLEX_BIT] = ~strap_sync.duplex;
      // 10Mbps strap withdraws the 100Mbps abilities from advertisement
      adv_d[RSL_ADV_100FD_BIT] = strap_sync.speed;
      adv_d[RSL_ADV_100HD_BIT] = strap_sync.speed;
      adv_d[RSL_ADV_10FD_BIT] = 1'b1;
      adv_d[RSL_ADV_10HD_BIT] = 1'b1;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        RSL_REG_CTRL:
        begin
          ctrl_d[RSL_CTRL_SPEED_BIT] = req.wdata[RSL_CTRL_SPEED_BIT];
          ctrl_d[RSL_CTRL_ANEN_BIT] = req.wdata[RSL_CTRL_ANEN_BIT];
          ctrl_d[RSL_CTRL_ISO_BIT] = req.wdata[RSL_CTRL_ISO_BIT];
          ctrl_d[RSL_CTRL_DUPLEX_BIT] = req.wdata[RSL_CTRL_DUPLEX_BIT];
        end
        RSL_REG_ADV:
        begin
          adv_d[RSL_ADV_100FD_BIT] = req.wdata[RSL_ADV_100FD_BIT];
          adv_d[RSL_ADV_100HD_BIT] = req.wdata[RSL_ADV_100HD_BIT];
          adv_d[RSL_ADV_10FD_BIT] = req.wdata[RSL_ADV_10FD_BIT];
          adv_d[RSL_ADV_10HD_BIT] = req.wdata[RSL_ADV_10HD_BIT];
        end
        RSL_REG_OPT:
        begin
          opt_d[RSL_OPT_BCAST_OFF_BIT] = req.wdata[RSL_OPT_BCAST_OFF_BIT];
        end
        default:
        begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    ctrl_q <= ctrl_d;
    adv_q <= adv_d;
    opt_q <= opt_d;
  end

  // derived configuration
  assign mgmt_addr = {RSL_MGMT_ADDR_HI, strap_q.mgmt_addr};
  assign bcast_en = ~strap_q.bcast_off & ~opt_q[RSL_OPT_BCAST_OFF_BIT];
  assign mode_bits = strap_q.mode;

  // address 0 answers as broadcast only while broadcast stays enabled
  always_comb
  begin
    mgmt_addr_hit = 1'b0;
    if (state_q == RSL_ST_RUN)
    begin
      mgmt_addr_hit = (mgmt_req_addr == mgmt_addr) ||
                      (bcast_en && (mgmt_req_addr == RSL_BCAST_ADDR));
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[RSL_STS_ADDR_LSB +: 3] = strap_q.mgmt_addr;
    status_word[RSL_STS_BCAST_BIT] = bcast_en;
    status_word[RSL_STS_MODE_LSB +: 3] = mode_bits;
    status_word[RSL_STS_ISO_BIT] = strap_q.isolate;
    status_word[RSL_STS_SPEED_BIT] = strap_q.speed;
    status_word[RSL_STS_DUPLEX_BIT] = strap_q.duplex;
    status_word[RSL_STS_VALID_BIT] = (state_q == RSL_ST_RUN);
  end

  // read data stand for one cycle only, zero otherwise
  always_comb
  begin
    rdata_d = '0;
    if (rstn && req.rd)
    begin
      unique case (req.addr)
        RSL_REG_CTRL:
        begin
          rdata_d = ctrl_q;
        end
        RSL_REG_ADV:
        begin
          rdata_d = adv_q;
        end
        RSL_REG_OPT:
        begin
          rdata_d = opt_q;
        end
        RSL_REG_STRAP:
        begin
          rdata_d = status_word;
        end
        default:
        begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    reg_rdata <= rdata_d;
  end

  always_comb
  begin
    cfg.mgmt_addr = mgmt_addr;
    cfg.bcast_en = bcast_en;
    cfg.mode_rmii = (mode_bits == RSL_MODE_RMII);
    cfg.mode_b2b = (mode_bits == RSL_MODE_B2B);
    cfg.mode_reserved = !cfg.mode_rmii && !cfg.mode_b2b;
    cfg.isolate = ctrl_q[RSL_CTRL_ISO_BIT];
    cfg.speed100 = ctrl_q[RSL_CTRL_SPEED_BIT];
    cfg.full_duplex = ctrl_q[RSL_CTRL_DUPLEX_BIT];
    cfg.an_enable = ctrl_q[RSL_CTRL_ANEN_BIT];
  end

  assign straps_valid = (state_q == RSL_ST_RUN);

endmodule
`default_nettype wire

//--- tb/rsl_board_pulls.sv
// board strap resistors: each strap pin rests at its resistor level
// assumes the device output enable is high while it drives the pin
`timescale 1ns/10ps
`default_nettype none
module rsl_board_pulls
(
  input wire rsl_pkg::rsl_straps_t pull,
  input wire rsl_pkg::rsl_straps_t pin_o,
  input wire rsl_pkg::rsl_straps_t pin_oe,
  output rsl_pkg::rsl_straps_t pin
);
  import rsl_pkg::*;
  // a released pin returns to the resistor level, never the last driven value
  assign pin = (pin_o & pin_oe) | (pull & ~pin_oe);
endmodule
`default_nettype wire

//--- tb/rsl_strap_latch_chk.sv
// strap latch checker: port level relations of capture, pins and decode
// assumes a bind onto rsl_strap_latch, one clock domain
`timescale 1ns/10ps
`default_nettype none
module rsl_strap_latch_chk
(
  input wire logic clk,
  input wire logic rstn,
  input wire rsl_pkg::rsl_straps_t strap_pin_i,
  input wire rsl_pkg::rsl_straps_t strap_pin_o,
  input wire rsl_pkg::rsl_straps_t strap_pin_oe,
  input wire rsl_pkg::rsl_straps_t strap_func_out,
  input wire logic reg_wr,
  input wire logic [4:0] mgmt_req_addr,
  input wire logic mgmt_addr_hit,
  input wire rsl_pkg::rsl_cfg_t cfg,
  input wire logic straps_valid
);
  import rsl_pkg::*;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_pins_input_first: assert property (
    $rose(rstn) |-> strap_pin_oe == '0 ##1 strap_pin_oe == '0 ##1 strap_pin_oe == '1)
    else $error("pin enable timing wrong");
  a_valid_on_release: assert property (
    $rose(rstn) |-> !straps_valid ##1 straps_valid)
    else $error("capture timing wrong");
  a_pins_driven: assert property (
    straps_valid && $past(straps_valid) |-> strap_pin_oe == '1)
    else $error("pins not driven");
  a_pins_follow: assert property (
    strap_pin_oe == '1 |-> strap_pin_o == $past(strap_func_out))
    else $error("pin value wrong");
  a_addr_hi_zero: assert property (
    straps_valid |-> cfg.mgmt_addr[4:3] == RSL_MGMT_ADDR_HI)
    else $error("upper address bits set");
  a_hit_decode: assert property (
    mgmt_addr_hit == (straps_valid && (mgmt_req_addr == cfg.mgmt_addr
      || (mgmt_req_addr == 5'h00 && cfg.bcast_en))))
    else $error("address match wrong");
  a_cfg_speed_dup: assert property (
    $rose(straps_valid) |-> cfg.speed100 == $past(strap_pin_i.speed, 2)
      && cfg.full_duplex != $past(strap_pin_i.duplex, 2)
      && cfg.isolate == $past(strap_pin_i.isolate, 2))
    else $error("control capture wrong");
  a_cfg_mode_addr: assert property (
    $rose(straps_valid) |-> cfg.mgmt_addr[2:0] == $past(strap_pin_i.mgmt_addr, 2)
      && cfg.bcast_en != $past(strap_pin_i.bcast_off, 2)
      && cfg.mode_rmii == ($past(strap_pin_i.mode, 2) == RSL_MODE_RMII)
      && cfg.mode_b2b == ($past(strap_pin_i.mode, 2) == RSL_MODE_B2B))
    else $error("mode or address capture wrong");
  a_cfg_hold: assert property (
    straps_valid && $past(straps_valid) && !$past(reg_wr) |-> $stable(cfg))
    else $error("config moved without a write");
endmodule
`default_nettype wire

//--- tb/tb.sv
// strap latch testbench: random and corner strap sets, one reset each
// assumes the board pull model and a bound checker
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rsl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  rsl_straps_t pull = '0, pin, pin_o, pin_oe, func_out = '0;
  logic [4:0] reg_addr = 5'h00, req = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, hit, valid;
  rsl_cfg_t cfg;
  logic [31:0] lfsr_q = 32'hFF66B41B;
  int mismatches = 0, comparisons = 0;
  rsl_strap_latch dut (.clk(clk), .rstn(rstn), .strap_pin_i(pin), .strap_pin_o(pin_o),
    .strap_pin_oe(pin_oe), .strap_func_out(func_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .mgmt_req_addr(req), .mgmt_addr_hit(hit), .cfg(cfg), .straps_valid(valid));
  rsl_board_pulls board (.pull(pull), .pin_o(pin_o), .pin_oe(pin_oe), .pin(pin));
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_ctrl(input rsl_straps_t s);
    return {2'h0, s.speed, 1'b1, 1'b0, s.isolate, 1'b0, !s.duplex, 8'h00};
  endfunction
  function automatic logic [15:0] exp_sts(input rsl_straps_t s);
    return {1'b1, 5'h00, s.duplex, s.speed, s.isolate, s.mode, !s.bcast_off, s.mgmt_addr};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(32'(rdata), 32'(e));
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  initial
  begin
    rsl_straps_t s;
    for (int i = 0; i < 10; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      s = lfsr_q[9:0];
      if (i == 0)
        s = 10'h08B;
      if (i == 1 || i == 2)
        s.mgmt_addr = 3'h0;
      if (i == 2)
        s.bcast_off = 1'b1;
      // step the mode so every pattern is latched at least once
      s.mode = 3'(i + 1);
      @(posedge clk);
      rstn <= 1'b0;
      pull <= s;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      check(32'(valid), 32'h1);
      check({22'h0, pin_oe}, 32'h0);
      @(posedge clk);
      #1;
      check({22'h0, pin_oe}, 32'h3FF);
      // late strap changes must not reach the latched setup
      pull <= ~s;
      func_out <= lfsr_q[19:10];
      rd(RSL_REG_CTRL, exp_ctrl(s));
      rd(RSL_REG_ADV, {7'h00, s.speed, s.speed, 2'h3, RSL_ADV_SELECTOR});
      rd(RSL_REG_STRAP, exp_sts(s));
      check({22'h0, pin}, {22'h0, func_out});
      check(32'(cfg.mgmt_addr), 32'(s.mgmt_addr));
      check(32'(cfg.mode_reserved), 32'(s.mode != 3'h1 && s.mode != 3'h5));
      req <= 5'h00;
      #1;
      check(32'(hit), 32'(s.mgmt_addr == 3'h0 || !s.bcast_off));
      wr(RSL_REG_OPT, 16'h0200);
      #1;
      check(32'(hit), 32'(s.mgmt_addr == 3'h0));
      rd(RSL_REG_OPT, 16'h0200);
      rd(5'h1F, 16'h0000);
      check(32'(cfg.an_enable), 32'h1);
      // writable control and advertisement bits, status stays read only
      wr(RSL_REG_CTRL, 16'hFFFF);
      rd(RSL_REG_CTRL, 16'h3500);
      check(32'(cfg.full_duplex), 32'h1);
      check(32'(cfg.isolate), 32'h1);
      wr(RSL_REG_ADV, 16'hFFFF);
      rd(RSL_REG_ADV, 16'h01E1);
      wr(RSL_REG_STRAP, 16'h0000);
      rd(RSL_REG_STRAP, exp_sts(s) & 16'hFFF7);
      req <= {2'h2, s.mgmt_addr};
      #1;
      check(32'(hit), 32'h0);
      req <= {2'h0, s.mgmt_addr};
      #1;
      check(32'(hit), 32'h1);
      $display("strap set %0d done", i);
    end
    stop_test;
  end
endmodule
bind rsl_strap_latch rsl_strap_latch_chk chk (.clk(clk), .rstn(rstn),
  .strap_pin_i(strap_pin_i), .strap_pin_o(strap_pin_o), .strap_pin_oe(strap_pin_oe),
  .strap_func_out(strap_func_out), .reg_wr(reg_wr), .mgmt_req_addr(mgmt_req_addr),
  .mgmt_addr_hit(mgmt_addr_hit), .cfg(cfg), .straps_valid(straps_valid));
`default_nettype wire
